//--- rtl/reset_source_tracker.sv
// Purpose: Combine reset sources, sequence release and record the cause
// Assumes: srst models the power-on event; supplies' requests are levels
// Notes:   Register port: 2-bit address, 8-bit data, read data one cycle late
//
// Functional notes
// - Low-power and main brown-out requests are ORed into one brown-out.
// - Low-power detector runs only when its config bit is set; erased means off.
// - Reset pin works when low-voltage-program bit or pin-enable bit is one.
// - Enabled pin held low keeps device in reset; weak pull-up default on.
// - Short glitches on the reset pin are filtered out.
// - The device never drives the reset pin.
// - Disabled pin is a plain input with software-controlled pull-up.
// - Watchdog timeout resets only when awake and clears timeout; it clears power-down only in sleep.
// - Reset instruction resets and clears only its own flag.
// - Stack faults reset only when enabled; each sets its own flag.
// - Programming mode exit acts like power-on reset for flags, status, timer and release.
// - After power or brown-out, wait for timer, oscillator and pin release.
// - Timers run regardless of pin; release starts execution at once.
// - Power-up timer, when enabled, delays only power-on and brown-out.
// - Power-on sets timeout and power-down and loads flags 00-1 110x.
// - Brown-out clears brown-out flag, stacks, sets pin and instruction flags.
// - Power-on clears power-on flag; firmware sets it afterwards.
// - Watchdog clears its flag and timeout; pin reset clears pin flag.
// - Resets load vector 0000h; wake-ups resume at next instruction.
// - Interrupt wake-up with global enable jumps to vector 0004h.
// - Stack flags set by hardware; firmware may write zero.
// - Watchdog, pin, instruction flags cleared by hardware; firmware writes one.
// - Power-up timer gives 64 ms, enabled when its active-low bit is clear.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module reset_source_tracker
	import reset_tracker_pkg::*;
#(
	parameter int unsigned POWER_UP_COUNT = POWER_UP_CYCLES,
	parameter int unsigned FILTER_COUNT = GLITCH_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        mainBrownoutReq,
	input  wire logic        lowPowerBrownoutReq,
	input  wire logic        lowPowerBrownoutCfg,
	input  wire logic        resetPinEnableCfg,
	input  wire logic        lowVoltageProgramCfg,
	input  wire logic        stackFaultResetEnableCfg,
	input  wire logic        powerUpTimerEnableN,
	input  wire logic        programModeExit,
	input  wire logic        externalResetPinIn,
	output logic             externalResetPinOut,
	output logic             externalResetPinOeN,
	output logic             pinPullupEn,
	output logic             pinGpioValue,
	input  wire logic        watchdogTimeout,
	input  wire logic        resetInstruction,
	input  wire logic        stackOverflow,
	input  wire logic        stackUnderflow,
	input  wire logic        sleeping,
	input  wire logic        interruptWake,
	input  wire logic        globalInterruptEnable,
	input  wire logic        oscStartupDone,
	input  wire logic [15:0] nextPc,
	output logic             coreReset,
	output logic             pcLoad,
	output logic [15:0]      pcValue,
	output logic             pushReturn,
	input  wire logic [1:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [7:0]       regRdata
);
	import reset_tracker_pkg::*;

	typedef struct packed {
		seq_state_e  seq;
		logic [31:0] powerUpCnt;
		logic        powerUpDone;
		logic        coldStart;
		logic [2:0]  holdCnt;
		logic [7:0]  flags;
		logic        timeoutSt;
		logic        pwrdownSt;
		logic        pullupSw;
		logic        pcLoad;
		logic [15:0] pcValue;
		logic        push;
		logic [7:0]  rdata;
	} state_s;

	state_s cur_q, nxt_d;
	logic   pinFiltered;
	logic   pinEnabled;
	logic   brownout;
	logic   pinReset;
	logic   stackFault;
	logic   powerOn;
	logic   anyWarm;

	// Reset pin synchroniser and deglitcher
	pin_glitch_filter #(
		.STABLE (FILTER_COUNT)
	) pin_glitch_filter_inst (
		.ref_clk (ref_clk),
		.srst    (srst),
		.pinIn   (externalResetPinIn),
		.pinOut  (pinFiltered)
	);

	// Source combination
	assign pinEnabled = lowVoltageProgramCfg | resetPinEnableCfg;
	assign brownout   = mainBrownoutReq | (lowPowerBrownoutReq & lowPowerBrownoutCfg);
	assign pinReset   = pinEnabled & ~pinFiltered;
	assign stackFault = stackFaultResetEnableCfg & (stackOverflow | stackUnderflow);
	assign powerOn    = programModeExit;
	assign anyWarm    = resetInstruction | stackFault; // Watchdog in sleep is a wake, not a reset

	// Pin is input only; pull-up follows enable or software
	assign externalResetPinOut = 1'b1;
	assign externalResetPinOeN = 1'b1;
	assign pinPullupEn         = pinEnabled | cur_q.pullupSw;
	assign pinGpioValue        = pinEnabled ? 1'b1 : pinFiltered;

	// Sequencer, flag updates and register port
	always_comb begin
		nxt_d        = cur_q;
		nxt_d.pcLoad = 1'b0;
		nxt_d.push   = 1'b0;
		nxt_d.rdata  = 8'h00;

		// Firmware writes: stack flags clear on zero, cause flags rearm on one
		if (regWr && regAddr == ADDR_FLAGS) begin
			nxt_d.flags = regWdata & FLAGS_IMPL_MASK;
		end
		if (regWr && regAddr == ADDR_PULLUP) begin
			nxt_d.pullupSw = regWdata[0];
		end

		// Power-up timer counts whenever armed, independent of the pin
		if (!cur_q.powerUpDone) begin
			if (powerUpTimerEnableN || cur_q.powerUpCnt >= POWER_UP_COUNT - 1) begin
				nxt_d.powerUpDone = 1'b1;
			end else begin
				nxt_d.powerUpCnt = cur_q.powerUpCnt + 32'h1;
			end
		end

		// Hardware events win over firmware writes
		if (powerOn) begin
			nxt_d.flags     = FLAGS_POR_VAL;
			nxt_d.timeoutSt = 1'b1;
			nxt_d.pwrdownSt = 1'b1;
		end else if (brownout) begin
			nxt_d.flags[BIT_BROWNOUT] = 1'b0;
			nxt_d.flags[BIT_STACK_OVER]  = 1'b0;
			nxt_d.flags[BIT_STACK_UNDER] = 1'b0;
			nxt_d.flags[BIT_PIN]      = 1'b1;
			nxt_d.flags[BIT_INSTR]    = 1'b1;
			nxt_d.flags[BIT_WDT]      = 1'b1;
			nxt_d.timeoutSt = 1'b1;
			nxt_d.pwrdownSt = 1'b1;
		end else begin
			if (watchdogTimeout) begin
				nxt_d.timeoutSt = 1'b0;
				if (sleeping) begin
					nxt_d.pwrdownSt = 1'b0;
				end else begin
					nxt_d.flags[BIT_WDT] = 1'b0;
				end
			end
			if (pinReset && cur_q.seq == SEQ_RUN) begin
				nxt_d.flags[BIT_PIN] = 1'b0;
				if (sleeping) begin
					nxt_d.timeoutSt = 1'b1;
					nxt_d.pwrdownSt = 1'b0;
				end
			end
			if (resetInstruction) begin
				nxt_d.flags[BIT_INSTR] = 1'b0;
			end
			if (stackFaultResetEnableCfg && stackOverflow) begin
				nxt_d.flags[BIT_STACK_OVER] = 1'b1;
			end
			if (stackFaultResetEnableCfg && stackUnderflow) begin
				nxt_d.flags[BIT_STACK_UNDER] = 1'b1;
			end
			if (sleeping && interruptWake) begin
				nxt_d.timeoutSt = 1'b1;
				nxt_d.pwrdownSt = 1'b0;
			end
		end

		// Release sequence
		case (cur_q.seq)
			SEQ_HOLD: begin
				if (cur_q.holdCnt >= 3'(RESET_HOLD - 1)) begin
					nxt_d.seq = SEQ_WAIT;
				end else begin
					nxt_d.holdCnt = cur_q.holdCnt + 3'h1;
				end
			end
			SEQ_WAIT: begin
				if ((cur_q.powerUpDone || !cur_q.coldStart) && oscStartupDone && !pinReset) begin
					nxt_d.seq     = SEQ_RUN;
					nxt_d.pcLoad  = 1'b1;
					nxt_d.pcValue = RESET_VECTOR;
				end
			end
			SEQ_RUN: begin
				if (sleeping && !anyWarm && !pinReset) begin
					if (interruptWake && globalInterruptEnable) begin
						nxt_d.pcLoad  = 1'b1;
						nxt_d.pcValue = IRQ_VECTOR;
						nxt_d.push    = 1'b1;
					end else if (interruptWake || watchdogTimeout) begin
						nxt_d.pcLoad  = 1'b1;
						nxt_d.pcValue = nextPc;
					end
				end
			end
			default: nxt_d.seq = SEQ_HOLD;
		endcase

		// Any reset source sends the sequencer back to hold
		if (powerOn || brownout || pinReset || stackFault || resetInstruction
			|| (watchdogTimeout && !sleeping)) begin
			nxt_d.seq     = SEQ_HOLD;
			nxt_d.holdCnt = 3'h0;
			nxt_d.pcLoad  = 1'b0;
			nxt_d.push    = 1'b0;
		end
		if (powerOn || brownout) begin
			nxt_d.coldStart = 1'b1;
			nxt_d.powerUpDone = 1'b0;
			nxt_d.powerUpCnt  = 32'h0;
		end else if (cur_q.seq == SEQ_RUN) begin
			nxt_d.coldStart = 1'b0;
		end

		// Read port; unused bits read as zero
		if (regRd) begin
			case (regAddr)
				ADDR_FLAGS:  nxt_d.rdata = cur_q.flags & FLAGS_IMPL_MASK;
				ADDR_STATUS: begin
					nxt_d.rdata[BIT_TIMEOUT] = cur_q.timeoutSt;
					nxt_d.rdata[BIT_PWRDOWN] = cur_q.pwrdownSt;
				end
				ADDR_PULLUP: nxt_d.rdata = {7'h00, cur_q.pullupSw};
				default:     nxt_d.rdata = 8'h00;
			endcase
		end
	end

	// State register; srst is the power-on event
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cur_q           <= '0;
			cur_q.seq       <= SEQ_HOLD;
			cur_q.coldStart <= 1'b1;
			cur_q.flags     <= FLAGS_POR_VAL;
			cur_q.timeoutSt <= 1'b1;
			cur_q.pwrdownSt <= 1'b1;
		end else begin
			cur_q <= nxt_d;
		end
	end

	assign coreReset  = (cur_q.seq != SEQ_RUN);
	assign pcLoad     = cur_q.pcLoad;
	assign pcValue    = cur_q.pcValue;
	assign pushReturn = cur_q.push;
	assign regRdata   = cur_q.rdata;
endmodule

//--- rtl/reset_tracker_pkg.sv
// Purpose: Shared constants for the reset source tracker
// Assumes: 250 MHz system clock, 8-bit register port
// Notes:   Flag bit positions follow the cause register layout
package reset_tracker_pkg;
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned POWER_UP_MS     = 64;
	localparam int unsigned POWER_UP_CYCLES = POWER_UP_MS * 1000 * CLK_MHZ;
	localparam int unsigned GLITCH_NS       = 100;
	localparam int unsigned GLITCH_CYCLES   = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RESET_HOLD      = 4;

	localparam logic [1:0]  ADDR_FLAGS      = 2'h0;
	localparam logic [1:0]  ADDR_STATUS     = 2'h1;
	localparam logic [1:0]  ADDR_PULLUP     = 2'h2;

	localparam int unsigned BIT_STACK_OVER  = 7;
	localparam int unsigned BIT_STACK_UNDER = 6;
	localparam int unsigned BIT_WDT         = 4;
	localparam int unsigned BIT_PIN         = 3;
	localparam int unsigned BIT_INSTR       = 2;
	localparam int unsigned BIT_POWERON     = 1;
	localparam int unsigned BIT_BROWNOUT    = 0;
	localparam int unsigned BIT_TIMEOUT     = 1;
	localparam int unsigned BIT_PWRDOWN     = 0;

	localparam logic [7:0]  FLAGS_IMPL_MASK = 8'hDF;
	localparam logic [7:0]  FLAGS_POR_VAL   = 8'h1C;
	localparam logic [15:0] RESET_VECTOR    = 16'h0000;
	localparam logic [15:0] IRQ_VECTOR      = 16'h0004;

	typedef enum logic [1:0] {
		SEQ_HOLD  = 2'b00,
		SEQ_WAIT  = 2'b01,
		SEQ_RUN   = 2'b11
	} seq_state_e;
endpackage

//--- rtl/pin_glitch_filter.sv
// Purpose: Synchronise and deglitch a slow input pin
// Assumes: Pin is asynchronous to the clock
// Notes:   Output changes only after the new level is stable for STABLE cycles
`timescale 1ns/1ps
module pin_glitch_filter #(
	parameter int unsigned STABLE = 25
) (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic pinIn,
	output logic      pinOut
);
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic [15:0] cnt;
		logic        out;
	} filt_s;
	filt_s cur_q, nxt_d;

	// Two-stage synchroniser, then stability counter
	always_comb begin
		nxt_d    = cur_q;
		nxt_d.s1 = pinIn;
		nxt_d.s2 = cur_q.s1;
		if (cur_q.s2 == cur_q.out) begin
			nxt_d.cnt = '0;
		end else if (cur_q.cnt >= 16'(STABLE - 1)) begin
			nxt_d.out = cur_q.s2;
			nxt_d.cnt = '0;
		end else begin
			nxt_d.cnt = cur_q.cnt + 16'h0001;
		end
	end

	// State register; pin idles high
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cur_q <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, out: 1'b1};
		end else begin
			cur_q <= nxt_d;
		end
	end

	assign pinOut = cur_q.out;
endmodule

//--- verif/reset_pin_driver.sv
// Purpose: Far-side model of the reset pin driver and supply monitor
// Assumes: Called from bench procedures after a clock edge
// Notes:   A released pin rests high on the weak pull-up
`timescale 1ns/1ps
module reset_pin_driver (
	input  wire logic ref_clk,
	output logic      pinLevel,
	output logic      brownReq
);
	// Pin released and supply good at start
	initial begin
		pinLevel = 1'b1;
		brownReq = 1'b0;
	end
	// Hold the pin low for n edges, then let go
	task automatic press(input int n);
		pinLevel <= 1'b0;
		repeat (n) @(posedge ref_clk);
		pinLevel <= 1'b1;
	endtask
	// Supply sag lasting n edges
	task automatic sag(input int n);
		brownReq <= 1'b1;
		repeat (n) @(posedge ref_clk);
		brownReq <= 1'b0;
	endtask
endmodule

//--- verif/reset_source_tracker_sva.sv
// Purpose: Port checks for the reset source tracker
// Assumes: One clock, synchronous reset
// Notes:   Glitch check needs a filter of two cycles or more
`timescale 1ns/1ps
module reset_source_tracker_sva
	import reset_tracker_pkg::*;
#(
	parameter int unsigned FILTER_COUNT = GLITCH_CYCLES
) (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        resetPinEnableCfg,
	input wire logic        lowVoltageProgramCfg,
	input wire logic        externalResetPinIn,
	input wire logic        externalResetPinOeN,
	input wire logic        pinPullupEn,
	input wire logic        pinGpioValue,
	input wire logic        coreReset,
	input wire logic        pcLoad,
	input wire logic [15:0] pcValue,
	input wire logic        pushReturn,
	input wire logic [1:0]  regAddr,
	input wire logic        regRd,
	input wire logic [7:0]  regRdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic       pinOn;
	logic [7:0] lowCnt_q;
	// Pin function enabled
	assign pinOn = resetPinEnableCfg | lowVoltageProgramCfg;
	// Consecutive samples of an enabled pin held low
	always_ff @(posedge ref_clk) begin
		if (srst || !pinOn || externalResetPinIn) begin
			lowCnt_q <= 8'h00;
		end else if (lowCnt_q != 8'hFF) begin
			lowCnt_q <= lowCnt_q + 8'h01;
		end
	end
	// One-cycle low pulse while running
	sequence shortLow;
		pinOn && !coreReset && $fell(externalResetPinIn) ##1 $rose(externalResetPinIn);
	endsequence
	a_pin_never_driven: assert property (externalResetPinOeN) else $error("reset pin driven");
	a_pullup_when_on: assert property (pinOn |-> pinPullupEn && pinGpioValue) else $error("pin mode wrong");
	a_hold_after_por: assert property ($past(srst) |-> coreReset) else $error("ran too early");
	a_glitch_ignored: assert property (shortLow |=> !coreReset [*4]) else $error("glitch reset");
	a_long_low_resets: assert property (int'(lowCnt_q) >= FILTER_COUNT + 6 |-> coreReset)
		else $error("pin low ignored");
	a_push_vector: assert property (pushReturn |-> pcLoad && pcValue == IRQ_VECTOR) else $error("bad vector");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("read data stands");
	a_unmapped_zero: assert property (regRd && regAddr == 2'h3 |=> regRdata == 8'h00) else $error("hole");
	a_bit5_zero: assert property (regRd && regAddr == ADDR_FLAGS |=> !regRdata[5]) else $error("bit 5 set");
endmodule

//--- verif/reset_source_tracker_bench.sv
// Purpose: Self-checking bench for the reset source tracker
// Assumes: Short timer and filter counts for simulation
// Notes:   Bench drives one ns after each rising edge
`timescale 1ns/1ps
module reset_source_tracker_bench;
	import reset_tracker_pkg::*;
	logic        ref_clk = 1'b0, srst = 1'b1, externalResetPinIn, mainBrownoutReq;
	logic        lowPowerBrownoutReq = 1'b0, lowPowerBrownoutCfg = 1'b0, lowVoltageProgramCfg = 1'b0;
	logic        programModeExit = 1'b0, resetPinEnableCfg = 1'b1, stackFaultResetEnableCfg = 1'b0;
	logic        powerUpTimerEnableN = 1'b0, oscStartupDone = 1'b0, watchdogTimeout = 1'b0;
	logic        resetInstruction = 1'b0, stackOverflow = 1'b0, stackUnderflow = 1'b0, sleeping = 1'b0;
	logic        interruptWake = 1'b0, globalInterruptEnable = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [1:0]  regAddr = 2'h0;
	logic [7:0]  regWdata = 8'h00, regRdata;
	logic [15:0] nextPc = 16'h0100, pcValue;
	logic        externalResetPinOut, externalResetPinOeN, pinPullupEn, pinGpioValue, coreReset, pcLoad, pushReturn;
	int          miscompares = 0, check_count = 0;
	// Event selectors for the pulse task
	localparam int EV_INSTR = 0, EV_WDT = 1, EV_OVER = 2, EV_UNDER = 3, EV_WAKE = 4, EV_PROG = 5;
	// Clock at 250 MHz
	always #2 ref_clk = ~ref_clk;
	reset_pin_driver reset_pin_driver_inst (.ref_clk, .pinLevel(externalResetPinIn), .brownReq(mainBrownoutReq));
	reset_source_tracker #(.POWER_UP_COUNT(50), .FILTER_COUNT(3)) reset_source_tracker_inst (.ref_clk, .srst,
		.mainBrownoutReq, .lowPowerBrownoutReq, .lowPowerBrownoutCfg, .resetPinEnableCfg, .lowVoltageProgramCfg,
		.stackFaultResetEnableCfg, .powerUpTimerEnableN, .programModeExit, .externalResetPinIn,
		.externalResetPinOut, .externalResetPinOeN, .pinPullupEn, .pinGpioValue, .watchdogTimeout,
		.resetInstruction, .stackOverflow, .stackUnderflow, .sleeping, .interruptWake, .globalInterruptEnable,
		.oscStartupDone, .nextPc, .coreReset, .pcLoad, .pcValue, .pushReturn, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata);
	// Bus and compare helpers
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		tick();
		regWr <= 1'b0;
		tick();
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		regRd <= 1'b1;
		regAddr <= a;
		tick();
		regRd <= 1'b0;
		chk(regRdata, e);
		tick();
	endtask
	task automatic pulse(input int w);
		{programModeExit, interruptWake, stackUnderflow, stackOverflow, watchdogTimeout, resetInstruction} <= 6'h01 << w;
		tick();
		{programModeExit, interruptWake, stackUnderflow, stackOverflow, watchdogTimeout, resetInstruction} <= 6'h00;
	endtask
	// Wait for a reset to start, then count cycles until the core runs
	task automatic wait_run(output int n);
		int k;
		n = 0;
		for (k = 0; k < 20 && coreReset !== 1'b1; k++) tick();
		if (k == 20) begin
			miscompares++;
			$display("mismatch at %0t: reset never started", $time);
		end
		while (coreReset !== 1'b0) begin
			tick();
			n++;
			if (n > 500) begin
				miscompares++;
				$display("mismatch at %0t: core never released", $time);
				tally_and_finish();
			end
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		int n;
		int i;
		repeat (20) tick();
		srst <= 1'b0;
		repeat (80) tick();
		chk({7'h00, coreReset}, 8'h01);
		oscStartupDone <= 1'b1;
		wait_run(n);
		rd(ADDR_FLAGS, 8'h1C);
		rd(ADDR_STATUS, 8'h03);
		wr(ADDR_FLAGS, 8'hFF);
		rd(ADDR_FLAGS, 8'hDF);
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'h00);
		$display("test power-on done");
		pulse(EV_INSTR);
		wait_run(n);
		chk({7'h00, n < 50}, 8'h01);
		rd(ADDR_FLAGS, 8'hDB);
		wr(ADDR_FLAGS, 8'hDF);
		pulse(EV_WDT);
		wait_run(n);
		rd(ADDR_FLAGS, 8'hCF);
		rd(ADDR_STATUS, 8'h01);
		pulse(EV_OVER);
		repeat (8) tick();
		chk({7'h00, coreReset}, 8'h00);
		stackFaultResetEnableCfg <= 1'b1;
		for (i = 0; i < 2; i++) begin
			wr(ADDR_FLAGS, 8'h1F);
			if (i == 0) pulse(EV_OVER);
			else pulse(EV_UNDER);
			wait_run(n);
			rd(ADDR_FLAGS, (i == 0) ? 8'h9F : 8'h5F);
		end
		$display("test warm resets done");
		reset_pin_driver_inst.press(1);
		repeat (8) tick();
		chk({7'h00, coreReset}, 8'h00);
		wr(ADDR_FLAGS, 8'hDF);
		reset_pin_driver_inst.press(12);
		wait_run(n);
		rd(ADDR_FLAGS, 8'hD7);
		resetPinEnableCfg <= 1'b0;
		wr(ADDR_PULLUP, 8'h00);
		chk({7'h00, pinPullupEn}, 8'h00);
		wr(ADDR_PULLUP, 8'h01);
		chk({7'h00, pinPullupEn}, 8'h01);
		rd(ADDR_PULLUP, 8'h01);
		// Disabled pin held low is only a plain input
		fork
			reset_pin_driver_inst.press(12);
			begin
				repeat (9) tick();
				chk({6'h00, pinGpioValue, coreReset}, 8'h00);
				chk({6'h00, externalResetPinOut, externalResetPinOeN}, 8'h03);
			end
		join
		$display("test pin done");
		wr(ADDR_FLAGS, 8'hDF);
		reset_pin_driver_inst.sag(3);
		wait_run(n);
		chk({7'h00, n >= 50}, 8'h01);
		rd(ADDR_FLAGS, 8'h1E);
		lowPowerBrownoutReq <= 1'b1;
		repeat (4) tick();
		chk({7'h00, coreReset}, 8'h00);
		wr(ADDR_FLAGS, 8'hDF);
		lowPowerBrownoutCfg <= 1'b1;
		tick();
		lowPowerBrownoutReq <= 1'b0;
		wait_run(n);
		rd(ADDR_FLAGS, 8'h1E);
		sleeping <= 1'b1;
		globalInterruptEnable <= 1'b1;
		nextPc <= 16'h0042;
		pulse(EV_WAKE);
		chk({6'h00, pushReturn, pcLoad}, 8'h03);
		chk(pcValue[7:0], 8'h04);
		rd(ADDR_STATUS, 8'h02);
		globalInterruptEnable <= 1'b0;
		pulse(EV_WAKE);
		chk({6'h00, pushReturn, pcLoad}, 8'h01);
		chk(pcValue[7:0], 8'h42);
		pulse(EV_WDT);
		chk({6'h00, coreReset, pcLoad}, 8'h01);
		chk(pcValue[7:0], 8'h42);
		rd(ADDR_STATUS, 8'h00);
		sleeping <= 1'b0;
		$display("test brown-out and wake done");
		pulse(EV_PROG);
		wait_run(n);
		chk({6'h00, n >= 50, pcLoad}, 8'h03);
		chk(pcValue[7:0], 8'h00);
		rd(ADDR_FLAGS, 8'h1C);
		rd(ADDR_STATUS, 8'h03);
		wr(ADDR_FLAGS, 8'hDF);
		powerUpTimerEnableN <= 1'b1;
		srst <= 1'b1;
		repeat (2) tick();
		srst <= 1'b0;
		wait_run(n);
		chk({7'h00, n < 50}, 8'h01);
		rd(ADDR_FLAGS, 8'h1C);
		$display("test program exit and repeat power-on done");
		tally_and_finish();
	end
endmodule
bind reset_source_tracker reset_source_tracker_sva #(.FILTER_COUNT(FILTER_COUNT)) sva_inst (.ref_clk, .srst,
	.resetPinEnableCfg, .lowVoltageProgramCfg, .externalResetPinIn, .externalResetPinOeN, .pinPullupEn,
	.pinGpioValue, .coreReset, .pcLoad, .pcValue, .pushReturn, .regAddr, .regRd, .regRdata);
